// *** ifd_consts.vh ***
// Purpose: constants for the instruction format decoder
// Assumes: 12-bit instruction words, 8-bit data path
// Notes: widths, field positions, opcode patterns, phase and destination values
`ifndef IFD_CONSTS_VH
`define IFD_CONSTS_VH
`define IFD_INSTR_W 12
`define IFD_DATA_W 8
`define IFD_BYTE_OP_HI 11
`define IFD_BYTE_OP_LO 6
`define IFD_DEST_BIT 5
`define IFD_FILE_HI 4
`define IFD_FILE_LO 0
`define IFD_BIT_OP_HI 11
`define IFD_BIT_OP_LO 8
`define IFD_BITNUM_HI 7
`define IFD_BITNUM_LO 5
`define IFD_LIT_OP_HI 11
`define IFD_LIT_OP_LO 8
`define IFD_LIT8_HI 7
`define IFD_LIT8_LO 0
`define IFD_JMP_OP_HI 11
`define IFD_JMP_OP_LO 9
`define IFD_LIT9_HI 8
`define IFD_LIT9_LO 0
`define IFD_OP_ADD 6'h07
`define IFD_OP_AND 6'h05
`define IFD_OP_JMP 3'h5
`define IFD_OSC_PER_CYCLE 4
`define IFD_PHASE_W 2
`define IFD_PHASE_DECODE 2'h0
`define IFD_PHASE_EXEC 2'h3
`define IFD_DEST_ACC 1'b0
`endif

// *** ifd_alu.v ***
// Purpose: byte alu for add and and operations
// Assumes: purely combinational, same clock domain as caller
// Notes: half carry is the carry out of bit 3
`timescale 1ns/100ps
`default_nettype none
`include "ifd_consts.vh"
module ifd_alu #(
  parameter DATA_W = 8
) (
  input wire [DATA_W-1:0] acc_i,
  input wire [DATA_W-1:0] file_i,
  input wire sel_and_i,
  output reg [DATA_W-1:0] result_o,
  output reg carry_o,
  output reg half_carry_o,
  output reg zero_o
);
  reg [DATA_W:0] sum;
  reg [4:0] low_sum;
  always @* begin
    sum = {1'b0, acc_i} + {1'b0, file_i};
    low_sum = {1'b0, acc_i[3:0]} + {1'b0, file_i[3:0]};
    if (sel_and_i) begin
      result_o = acc_i & file_i;
    end else begin
      result_o = sum[DATA_W-1:0];
    end
    carry_o = sum[DATA_W];
    half_carry_o = low_sum[4];
    zero_o = (result_o == {DATA_W{1'b0}});
  end
endmodule // ifd_alu
`default_nettype wire

// *** ifd_decoder.v ***
// Purpose: decode 12-bit instruction words and execute add/and on file data
// Assumes: file data for the addressed register is presented by the datapath
// Notes: clock is the oscillator; one instruction cycle is four clocks
// Behaviour
// - byte ops: opcode 11:6, destination bit 5, file address 4:0
// - destination 0 writes accumulator, 1 writes back the file register
// - bit ops: opcode 11:8, bit number 7:5, file address 4:0
// - literal ops except jump: opcode 11:8, 8-bit literal 7:0
// - absolute jump: opcode 11:9, 9-bit target 8:0
// - add pattern adds accumulator and file, updates carry, half carry, zero
// - and pattern ANDs accumulator and file, updates zero only
// - one cycle per instruction, two when a test is true or pc changes
// - one instruction cycle spans four oscillator periods
`timescale 1ns/100ps
`default_nettype none
`include "ifd_consts.vh"
module ifd_decoder #(
  parameter INSTR_W = 12,
  parameter DATA_W = 8
) (
  input wire ref_clk_i,
  input wire resetn_i,
  input wire clk_en_i,
  input wire [INSTR_W-1:0] instr_i,
  input wire instr_valid_i,
  input wire [DATA_W-1:0] file_data_i,
  input wire pc_change_i,
  input wire test_true_i,
  input wire [DATA_W-1:0] acc_init_i,
  input wire acc_load_i,
  output reg [5:0] byte_opcode_o,
  output reg dest_file_o,
  output reg [4:0] file_addr_o,
  output reg [3:0] bit_opcode_o,
  output reg [2:0] bit_num_o,
  output reg [7:0] literal8_o,
  output reg [2:0] jump_opcode_o,
  output reg [8:0] literal9_o,
  output reg is_jump_o,
  output reg [DATA_W-1:0] acc_o,
  output reg [DATA_W-1:0] file_wdata_o,
  output reg file_we_o,
  output reg carry_flag_o,
  output reg half_carry_flag_o,
  output reg zero_flag_o,
  output reg [`IFD_PHASE_W-1:0] phase_o,
  output reg flush_o
);
  reg [INSTR_W-1:0] instr;
  reg [`IFD_PHASE_W-1:0] phase;
  reg two_cycle;
  wire [DATA_W-1:0] alu_result;
  wire alu_carry;
  wire alu_half;
  wire alu_zero;
  wire is_add;
  wire is_and;
  wire exec_now;

  assign is_add = instr[`IFD_BYTE_OP_HI:`IFD_BYTE_OP_LO] == `IFD_OP_ADD;
  assign is_and = instr[`IFD_BYTE_OP_HI:`IFD_BYTE_OP_LO] == `IFD_OP_AND;
  assign exec_now = phase == `IFD_PHASE_EXEC;

  ifd_alu #(
    .DATA_W(DATA_W)
  ) u_alu (
    .acc_i(acc_o),
    .file_i(file_data_i),
    .sel_and_i(is_and),
    .result_o(alu_result),
    .carry_o(alu_carry),
    .half_carry_o(alu_half),
    .zero_o(alu_zero)
  );

  always @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      phase <= `IFD_PHASE_DECODE;
      phase_o <= `IFD_PHASE_DECODE;
    end else if (clk_en_i) begin
      phase <= phase + 2'h1;
      phase_o <= phase + 2'h1;
    end
  end

  // latch word at the start of each instruction cycle
  always @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      instr <= {INSTR_W{1'b0}};
      byte_opcode_o <= 6'h00;
      dest_file_o <= 1'b0;
      file_addr_o <= 5'h00;
      bit_opcode_o <= 4'h0;
      bit_num_o <= 3'h0;
      literal8_o <= 8'h00;
      jump_opcode_o <= 3'h0;
      literal9_o <= 9'h000;
      is_jump_o <= 1'b0;
    end else if (clk_en_i && phase == `IFD_PHASE_DECODE) begin
      // a flushed slot executes as all zeros, a no-operation; the field outputs still follow instr_i
      if (instr_valid_i && !two_cycle) begin
        instr <= instr_i;
      end else begin
        instr <= {INSTR_W{1'b0}};
      end
      byte_opcode_o <= instr_i[`IFD_BYTE_OP_HI:`IFD_BYTE_OP_LO];
      dest_file_o <= instr_i[`IFD_DEST_BIT];
      file_addr_o <= instr_i[`IFD_FILE_HI:`IFD_FILE_LO];
      bit_opcode_o <= instr_i[`IFD_BIT_OP_HI:`IFD_BIT_OP_LO];
      bit_num_o <= instr_i[`IFD_BITNUM_HI:`IFD_BITNUM_LO];
      literal8_o <= instr_i[`IFD_LIT8_HI:`IFD_LIT8_LO];
      jump_opcode_o <= instr_i[`IFD_JMP_OP_HI:`IFD_JMP_OP_LO];
      literal9_o <= instr_i[`IFD_LIT9_HI:`IFD_LIT9_LO];
      is_jump_o <= instr_i[`IFD_JMP_OP_HI:`IFD_JMP_OP_LO] == `IFD_OP_JMP;
    end
  end

  always @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      two_cycle <= 1'b0;
      flush_o <= 1'b0;
    end else if (clk_en_i) begin
      if (exec_now) begin
        two_cycle <= pc_change_i | test_true_i;
        flush_o <= pc_change_i | test_true_i;
      end else if (phase == `IFD_PHASE_DECODE) begin
        two_cycle <= 1'b0;
      end
    end
  end

  // execute on the last phase so file data has settled
  always @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      acc_o <= {DATA_W{1'b0}};
      file_wdata_o <= {DATA_W{1'b0}};
      file_we_o <= 1'b0;
      carry_flag_o <= 1'b0;
      half_carry_flag_o <= 1'b0;
      zero_flag_o <= 1'b0;
    end else if (clk_en_i) begin
      file_we_o <= 1'b0;
      if (acc_load_i) begin
        acc_o <= acc_init_i;
      end else if (exec_now && (is_add || is_and)) begin
        if (instr[`IFD_DEST_BIT] == `IFD_DEST_ACC) begin
          acc_o <= alu_result;
        end else begin
          file_wdata_o <= alu_result;
          file_we_o <= 1'b1;
        end
        zero_flag_o <= alu_zero;
        if (is_add) begin
          carry_flag_o <= alu_carry;
          half_carry_flag_o <= alu_half;
        end
      end
    end
  end
endmodule // ifd_decoder
`default_nettype wire

// *** ifd_file_model.sv ***
// Purpose: file register model. Assumes: one clock. Notes: array reachable by the bench
`timescale 1ns/100ps
`default_nettype none
module ifd_file_model (
  input wire logic ref_clk_i,
  input wire logic [4:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic we_i,
  output logic [7:0] rdata_o
);
  logic [7:0] mem [0:31];
  assign rdata_o = mem[addr_i];
  always @(posedge ref_clk_i) if (we_i) mem[addr_i] <= wdata_i;
endmodule // ifd_file_model
`default_nettype wire

// *** ifd_decoder_assertions.sv ***
// Purpose: port checks. Assumes: clk_en_i high. Notes: refused slots skipped
`timescale 1ns/100ps
`default_nettype none
`include "ifd_consts.vh"
module ifd_chk (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic [11:0] instr_i,
  input wire logic [7:0] file_data_i,
  input wire logic pc_change_i,
  input wire logic [1:0] phase_o,
  input wire logic [5:0] byte_opcode_o,
  input wire logic dest_file_o,
  input wire logic [4:0] file_addr_o,
  input wire logic [7:0] literal8_o,
  input wire logic [7:0] acc_o,
  input wire logic file_we_o,
  input wire logic carry_flag_o,
  input wire logic zero_flag_o,
  input wire logic flush_o
);
  wire lat = phase_o == 2'h0 && !flush_o;
  wire ex = phase_o == 2'h3;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  property p_ph; 1'h1 |=> phase_o == $past(phase_o) + 2'h1; endproperty
  a_ph: assert property (p_ph) else $error("phase");
  property p_by; lat |=> {byte_opcode_o, dest_file_o, file_addr_o} == $past(instr_i); endproperty
  a_by: assert property (p_by) else $error("byte");
  property p_li; lat |=> literal8_o == $past(instr_i[7:0]); endproperty
  a_li: assert property (p_li) else $error("lit");
  // flushed slots execute as a no-operation, so they are excluded
  property p_ad; ex && !flush_o && byte_opcode_o == `IFD_OP_ADD && !dest_file_o |=>
    {carry_flag_o, acc_o} == $past(acc_o) + $past(file_data_i); endproperty
  a_ad: assert property (p_ad) else $error("add");
  property p_an; ex && !flush_o && byte_opcode_o == `IFD_OP_AND |=>
    $stable(carry_flag_o) && (dest_file_o || acc_o == ($past(acc_o) & $past(file_data_i))); endproperty
  a_an: assert property (p_an) else $error("and");
  property p_zf; ex && !flush_o && !dest_file_o && (byte_opcode_o == `IFD_OP_ADD || byte_opcode_o == `IFD_OP_AND) |=>
    zero_flag_o == (acc_o == 8'h00); endproperty
  a_zf: assert property (p_zf) else $error("zero");
  property p_we; file_we_o |-> dest_file_o && $stable(acc_o); endproperty
  a_we: assert property (p_we) else $error("dest");
  property p_fl; ex && pc_change_i |=> flush_o; endproperty
  a_fl: assert property (p_fl) else $error("flush");
endmodule // ifd_chk
bind ifd_decoder ifd_chk chk_u (.*);
`default_nettype wire

// *** tb_instr_format_decoder.sv ***
// Purpose: decoder bench. Assumes: 20 MHz clock. Notes: instr_i returns to zero one clock after each word
`timescale 1ns/100ps
`default_nettype none
module tb_instr_format_decoder;
  logic ref_clk_i = 1'h0, resetn_i = 1'h0, pc_change_i = 1'h0, acc_load_i = 1'h0, test_true_i = 1'h0;
  logic [11:0] instr_i = 12'h000;
  logic [7:0] acc_init_i = 8'h00;
  logic [7:0] file_data_i, acc_o, file_wdata_o, literal8_o;
  logic [5:0] byte_opcode_o;
  logic [4:0] file_addr_o;
  logic [3:0] bit_opcode_o;
  logic [2:0] bit_num_o, jump_opcode_o;
  logic [8:0] literal9_o;
  logic [1:0] phase_o;
  logic dest_file_o, is_jump_o, file_we_o, carry_flag_o, half_carry_flag_o, zero_flag_o, flush_o;
  int n_errors = 0, checked = 0;
  always #25 ref_clk_i = ~ref_clk_i;
  ifd_decoder dut_u (.*, .clk_en_i(1'h1), .instr_valid_i(1'h1));
  ifd_file_model part_u (.ref_clk_i, .addr_i(file_addr_o), .wdata_i(file_wdata_o), .we_i(file_we_o), .rdata_o(file_data_i));
  task stop_test;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task chk(input bit ok);
    checked++;
    if (!ok) begin
      n_errors++;
      $display("ERROR %0t mismatch", $time);
    end
  endtask
  task load(input logic [7:0] v);
    acc_init_i = v;
    acc_load_i = 1'h1;
    @(negedge ref_clk_i);
    acc_load_i = 1'h0;
  endtask
  // issue at phase 0, return once results stand
  task exec(input logic [11:0] w);
    int i;
    for (i = 0; i < 8 && phase_o !== 2'h0; i++) @(negedge ref_clk_i);
    if (i == 8) begin
      n_errors++;
      stop_test;
    end else begin
      instr_i = w;
      @(negedge ref_clk_i);
      instr_i = 12'h000;
      repeat (3) @(negedge ref_clk_i);
    end
  endtask
  task t_add;
    load(8'hFF);
    part_u.mem[3] = 8'h01;
    exec(12'h1E3);
    chk(file_we_o === 1'h1 && file_wdata_o === 8'h00 && acc_o === 8'hFF);
    chk(carry_flag_o === 1'h1 && half_carry_flag_o === 1'h1 && zero_flag_o === 1'h1);
  endtask
  task t_and;
    load(8'h17);
    part_u.mem[5] = 8'hC2;
    exec(12'h165);
    chk(file_we_o === 1'h1 && file_wdata_o === 8'h02 && zero_flag_o === 1'h0);
    part_u.mem[6] = 8'hE8;
    exec(12'h146);
    chk(acc_o === 8'h00 && half_carry_flag_o === 1'h1 && carry_flag_o === 1'h1);
    chk(zero_flag_o === 1'h1 && file_we_o === 1'h0);
  endtask
  task t_jump;
    pc_change_i = 1'h1;
    exec(12'hBA5);
    pc_change_i = 1'h0;
    chk(is_jump_o === 1'h1 && jump_opcode_o === 3'h5 && literal9_o === 9'h1A5);
    chk(bit_opcode_o === 4'hB && bit_num_o === 3'h5 && file_addr_o === 5'h05);
    chk(literal8_o === 8'hA5 && flush_o === 1'h1);
    part_u.mem[2] = 8'hC2;
    exec(12'h1C2);
    chk(acc_o === 8'h00 && flush_o === 1'h0);
  endtask
  task t_skip;
    test_true_i = 1'h1;
    exec(12'h000);
    test_true_i = 1'h0;
    chk(flush_o === 1'h1);
    exec(12'h1C2);
    chk(acc_o === 8'h00 && flush_o === 1'h0);
    exec(12'h1C2);
    chk(acc_o === 8'hC2 && zero_flag_o === 1'h0 && carry_flag_o === 1'h0);
  endtask
  initial begin
    repeat (2) @(negedge ref_clk_i);
    resetn_i = 1'h1;
    t_add;
    t_and;
    t_jump;
    t_skip;
    stop_test;
  end
endmodule // tb_instr_format_decoder
`default_nettype wire
